/* hdl/mmd_boot_check.sv */
// Boot-time check of the vector page: signature word or page checksum.
// Assumes program memory answers each read with a one-cycle ack.
`default_nettype none

module mmd_boot_check #(
    parameter int PAGE_WORDS = mmd_pkg::PAGE_WORDS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic rd_ack,
    input wire logic [31:0] rd_data,
    output logic rd_ff,
    output logic [31:0] rd_addr_ff,
    output logic done_ff,
    output logic fail_ff
);
    typedef enum logic [1:0] {BC_ISSUE, BC_WAIT, BC_STOP} mmd_bc_st_t;

    typedef struct packed {
        mmd_bc_st_t st;
        logic [15:0] idx;
        logic [31:0] sum;
        logic [31:0] sig;
        logic rd;
        logic done;
        logic fail;
    } mmd_bc_t;

    mmd_bc_t r, nxt;
    logic [31:0] sum_fin;
    logic is_sig;

    always_comb begin
        nxt = r;
        nxt.rd = 1'b0;
        nxt.done = 1'b0;
        is_sig = ({r.idx, 2'b00} == mmd_pkg::SIG_ADDR[17:0]);
        sum_fin = is_sig ? r.sum : r.sum + rd_data;
        case (r.st)
            BC_ISSUE: begin
                nxt.rd = 1'b1;
                nxt.st = BC_WAIT;
            end
            BC_WAIT: begin
                if (rd_ack) begin
                    // Checksum skips the signature word itself
                    nxt.sum = sum_fin; // RULE_12
                    if (is_sig) begin
                        nxt.sig = rd_data;
                    end
                    nxt.idx = r.idx + 16'h0001;
                    nxt.st = BC_ISSUE;
                    if (r.idx == 16'(PAGE_WORDS - 1)) begin
                        nxt.st = BC_STOP;
                        nxt.done = 1'b1;
                        nxt.fail = !(r.sig == mmd_pkg::SIG_VALUE || r.sig == sum_fin); // RULE_12
                    end
                end
            end
            BC_STOP: begin
            end
            default: nxt.st = BC_STOP;
        endcase
        if (reset) begin
            nxt = '0;
            nxt.st = BC_ISSUE;
        end
    end

    always_ff @(posedge ref_clk) begin
        r <= nxt;
    end

    assign rd_ff = r.rd;
    assign rd_addr_ff = mmd_pkg::FLASH_BASE + {14'h0000, r.idx, 2'b00};
    assign done_ff = r.done;
    assign fail_ff = r.fail;
endmodule

`default_nettype wire

/* hdl/mmd_decoder.sv */
// Address decoder and remap logic between the core bus and on-chip memories.
// Assumes program memory and the peripheral register block answer each
// one-cycle request with a one-cycle ack, at least one cycle later.
`default_nettype none

module mmd_decoder #(
    parameter int SRAM_WORDS = mmd_pkg::SRAM_WORDS,
    parameter int PAGE_WORDS = mmd_pkg::PAGE_WORDS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire mmd_pkg::mmd_core_req_t core_req,
    output mmd_pkg::mmd_core_rsp_t core_rsp_ff,
    output mmd_pkg::mmd_mem_req_t flash_req_ff,
    input wire logic flash_ack,
    input wire logic [31:0] flash_rdata,
    output mmd_pkg::mmd_mem_req_t mmr_req_ff,
    input wire logic mmr_ack,
    input wire logic [31:0] mmr_rdata,
    output logic boot_done_ff,
    output logic download_mode_ff,
    output logic [7:0] remap_select_register_ff
);
    localparam int AW = $clog2(SRAM_WORDS);

    typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_SRAM, ST_EXT} mmd_st_t;

    typedef struct packed {
        mmd_st_t st;
        logic remap;
        logic [1:0] lane;
        mmd_pkg::mmd_core_rsp_t rsp;
        mmd_pkg::mmd_mem_req_t flash;
        mmd_pkg::mmd_mem_req_t mmr;
        logic boot_done;
        logic dl_mode;
    } mmd_dec_t;

    mmd_dec_t r, nxt;

    logic sram_en;
    logic sram_wr;
    logic [3:0] sram_be;
    logic [AW-1:0] sram_idx;
    logic [31:0] sram_wdata;
    logic [31:0] sram_rdata;

    logic bc_rd;
    logic [31:0] bc_addr;
    logic bc_done;
    logic bc_fail;

    mmd_sram #(
        .WORDS(SRAM_WORDS),
        .AW(AW)
    ) u_sram (
        .ref_clk(ref_clk),
        .en(sram_en),
        .wr(sram_wr),
        .be(sram_be),
        .idx(sram_idx),
        .wdata(sram_wdata),
        .rdata_ff(sram_rdata)
    );

    // Stands in for the firmware's power-on routine before user code runs
    mmd_boot_check #(
        .PAGE_WORDS(PAGE_WORDS)
    ) u_boot (
        .ref_clk(ref_clk),
        .reset(reset),
        .rd_ack(flash_ack && r.st == ST_BOOT),
        .rd_data(flash_rdata),
        .rd_ff(bc_rd),
        .rd_addr_ff(bc_addr),
        .done_ff(bc_done),
        .fail_ff(bc_fail)
    );

    // Decode of the current request
    logic [31:0] a;
    logic [3:0] be;
    logic [31:0] wdata;
    logic in_low;
    logic in_sram;
    logic in_flash;
    logic in_mmr;
    logic is_remap;
    logic kernel_hit;
    logic [31:0] sram_off;
    logic [31:0] flash_off;
    logic [31:0] rd_word;

    always_comb begin
        a = core_req.addr;
        case (core_req.size)
            mmd_pkg::SZ_BYTE: begin
                be = 4'h1 << a[1:0];
                wdata = {4{core_req.wdata[7:0]}};
            end
            mmd_pkg::SZ_HALF: begin
                be = 4'h3 << {a[1], 1'b0};
                wdata = {2{core_req.wdata[15:0]}};
            end
            default: begin
                be = 4'hF;
                wdata = core_req.wdata;
            end
        endcase
        // Vectors below VEC_TOP fall in this window and follow the remap
        in_low = a < mmd_pkg::LOW_WIN_SIZE; // RULE_04 RULE_13
        in_sram = a >= mmd_pkg::SRAM_BASE
            && a < mmd_pkg::SRAM_BASE + mmd_pkg::SRAM_SIZE; // RULE_01
        in_flash = a >= mmd_pkg::FLASH_BASE
            && a < mmd_pkg::FLASH_BASE + mmd_pkg::FLASH_SIZE;
        in_mmr = a >= mmd_pkg::MMR_BASE
            && a < mmd_pkg::MMR_BASE + mmd_pkg::MMR_SIZE; // RULE_03
        is_remap = {a[31:2], 2'b00} == mmd_pkg::REMAP_ADDR;
        sram_off = in_low ? a : a - mmd_pkg::SRAM_BASE;
        flash_off = in_low ? a : a - mmd_pkg::FLASH_BASE;
        // Top 2 kB of program memory hold the firmware
        kernel_hit = in_flash && flash_off >= mmd_pkg::FLASH_USER_SIZE; // RULE_14
    end

    always_comb begin
        nxt = r;
        nxt.rsp.ack = 1'b0;
        nxt.rsp.abort = 1'b0;
        nxt.flash.valid = 1'b0;
        nxt.mmr.valid = 1'b0;
        sram_en = 1'b0;
        sram_wr = core_req.wr;
        sram_be = be;
        sram_idx = sram_off[AW+1:2];
        sram_wdata = wdata;
        rd_word = r.st == ST_SRAM ? sram_rdata : (flash_ack ? flash_rdata : mmr_rdata);
        case (r.st)
            ST_BOOT: begin
                // Core is held off until the vector page check is over
                nxt.flash.valid = bc_rd;
                nxt.flash.wr = 1'b0;
                nxt.flash.be = 4'hF;
                nxt.flash.addr = bc_addr;
                nxt.flash.wdata = 32'h0000_0000;
                if (bc_done) begin
                    nxt.boot_done = 1'b1; // RULE_10
                    nxt.dl_mode = bc_fail; // RULE_12
                    nxt.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (core_req.req) begin
                    nxt.lane = a[1:0];
                    if (is_remap) begin
                        // Firmware and user code share this write path
                        if (core_req.wr && be[0]) begin
                            nxt.remap = wdata[mmd_pkg::REMAP_BIT]; // RULE_08 RULE_16 RULE_17
                        end
                        nxt.rsp.ack = 1'b1;
                        nxt.rsp.rdata = {31'h0000_0000, r.remap} >> {a[1:0], 3'b000}; // RULE_20
                    end else if ((in_low && r.remap) || in_sram) begin
                        if (sram_off < mmd_pkg::SRAM_SIZE) begin
                            sram_en = 1'b1; // RULE_02
                            nxt.st = ST_SRAM;
                        end else begin
                            nxt.rsp.ack = 1'b1;
                            nxt.rsp.abort = 1'b1; // RULE_05
                        end
                    end else if ((in_low || in_flash) && !(kernel_hit && !core_req.kernel)) begin
                        nxt.flash.valid = 1'b1; // RULE_07
                        nxt.flash.wr = core_req.wr;
                        nxt.flash.be = be;
                        nxt.flash.addr = mmd_pkg::FLASH_BASE + flash_off;
                        nxt.flash.wdata = wdata;
                        nxt.st = ST_EXT;
                    end else if (in_mmr) begin
                        nxt.mmr.valid = 1'b1; // RULE_03
                        nxt.mmr.wr = core_req.wr;
                        nxt.mmr.be = be;
                        nxt.mmr.addr = a;
                        nxt.mmr.wdata = wdata;
                        nxt.st = ST_EXT;
                    end else begin
                        // Hidden firmware space and unmapped space both abort
                        nxt.rsp.ack = 1'b1;
                        nxt.rsp.abort = 1'b1; // RULE_05 RULE_11
                    end
                end
            end
            ST_SRAM: begin
                nxt.rsp.ack = 1'b1;
                nxt.rsp.rdata = rd_word >> {r.lane, 3'b000}; // RULE_06
                nxt.st = ST_IDLE;
            end
            ST_EXT: begin
                if (flash_ack || mmr_ack) begin
                    nxt.rsp.ack = 1'b1;
                    nxt.rsp.rdata = rd_word >> {r.lane, 3'b000}; // RULE_06
                    nxt.st = ST_IDLE;
                end
            end
            default: nxt.st = ST_IDLE;
        endcase
        // Any reset, whatever caused it, returns program memory to zero
        if (reset) begin
            nxt = '0;
            nxt.st = ST_BOOT;
            nxt.remap = mmd_pkg::REMAP_RST; // RULE_07 RULE_09 RULE_19
        end
    end

    always_ff @(posedge ref_clk) begin
        r <= nxt;
    end

    assign core_rsp_ff = r.rsp;
    assign flash_req_ff = r.flash;
    assign mmr_req_ff = r.mmr;
    assign boot_done_ff = r.boot_done;
    assign download_mode_ff = r.dl_mode;
    assign remap_select_register_ff = {{(mmd_pkg::REMAP_WIDTH - 1){1'b0}}, r.remap}; // RULE_20
endmodule

`default_nettype wire

/* hdl/mmd_pkg.sv */
// Constants and carrier types of the memory map and remap decoder.
// Assumes one processor clock and a synchronous active-high reset.
//
// Contract
// [RULE_01] Data RAM is decoded as 1536 words of 32 bits at 0x40000.
// [RULE_02] Data RAM takes byte, halfword and word reads and writes, 32 bits wide.
// [RULE_03] The top 4 kB region is reserved for peripheral registers; the code decodes its 4 kB at 0xFFFF0000 instead.
// [RULE_04] The lowest 94 kB mirror either program memory or data RAM.
// [RULE_05] Accesses outside every defined region are refused with a data abort.
// [RULE_06] Multi-byte values are little endian: low byte at lowest address.
// [RULE_07] After any reset program memory is mirrored at address zero.
// [RULE_08] Remap bit 0 at 0xFFFF0220: one puts RAM at zero, zero restores program memory.
// [RULE_09] Every reset source forces program memory back to address zero.
// [RULE_10] After reset firmware runs first, then the core starts at vector zero.
// [RULE_11] The factory firmware region is hidden from user accesses.
// [RULE_12] Boot checks word 0x14 for signature or page checksum, else download mode.
// [RULE_13] Vectors 0x00 to 0x20 come from whichever memory the remap selects.
// [RULE_14] Of 96 kB program memory, 94 kB are user and 2 kB firmware.
// [RULE_15] The core changes remap only when running from absolute program addresses.
// [RULE_16] The remap control register is 8 bits, readable and writable.
// [RULE_17] Remap value after reset is what the boot firmware loads.
// [RULE_18] Software writes zeros to reserved remap bits 7 to 1.
// [RULE_19] Reset clears the remap bit so program memory sits at zero.
// [RULE_20] Remap reads return the selection in bit 0, zeros above.
`default_nettype none

package mmd_pkg;
    localparam logic [31:0] LOW_WIN_SIZE = 32'h0001_7800;
    localparam logic [31:0] VEC_TOP = 32'h0000_0020;
    localparam logic [31:0] SRAM_BASE = 32'h0004_0000;
    localparam logic [31:0] SRAM_SIZE = 32'h0000_1800;
    localparam int SRAM_WORDS = 1536;
    localparam logic [31:0] FLASH_BASE = 32'h0008_0000;
    localparam logic [31:0] FLASH_SIZE = 32'h0001_8000;
    localparam logic [31:0] FLASH_USER_SIZE = 32'h0001_7800;
    localparam logic [31:0] MMR_BASE = 32'hFFFF_0000;
    localparam logic [31:0] MMR_SIZE = 32'h0000_1000;
    localparam logic [31:0] REMAP_ADDR = 32'hFFFF_0220;
    localparam int REMAP_WIDTH = 8;
    localparam int REMAP_BIT = 0;
    localparam logic REMAP_RST = 1'b0;
    localparam logic [31:0] SIG_ADDR = 32'h0000_0014;
    localparam logic [31:0] SIG_VALUE = 32'h2701_1970;
    localparam int PAGE_WORDS = 128;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;

    typedef struct packed {
        logic req;
        logic wr;
        logic kernel;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mmd_core_req_t;

    typedef struct packed {
        logic ack;
        logic abort;
        logic [31:0] rdata;
    } mmd_core_rsp_t;

    typedef struct packed {
        logic valid;
        logic wr;
        logic [3:0] be;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mmd_mem_req_t;
endpackage

`default_nettype wire

/* hdl/mmd_sram.sv */
// Word-wide data RAM with per-byte write enables and a registered read.
// Assumes the decoder presents word indices inside the array.
`default_nettype none

module mmd_sram #(
    parameter int WORDS = mmd_pkg::SRAM_WORDS,
    parameter int AW = $clog2(WORDS)
) (
    input wire logic ref_clk,
    input wire logic en,
    input wire logic wr,
    input wire logic [3:0] be,
    input wire logic [AW-1:0] idx,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata_ff
);
    // Four byte-lane arrays read together so a word fetch completes in one access
    // One array per byte lane keeps each lane array to a single process
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            logic [7:0] lane_mem [WORDS];

            always_ff @(posedge ref_clk) begin
                if (en && wr && be[g]) begin
                    lane_mem[idx] <= wdata[8*g +: 8]; // RULE_02
                end
                if (en) begin
                    rdata_ff[8*g +: 8] <= lane_mem[idx];
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

/* tb/mmd_decoder_properties.sv */
// Port-level checks of the memory map and remap decoder.
// Assumes it is bound to mmd_decoder; one clock, synchronous reset.
`default_nettype none

module mmd_decoder_properties #(
    parameter int SRAM_WORDS = mmd_pkg::SRAM_WORDS,
    parameter int PAGE_WORDS = mmd_pkg::PAGE_WORDS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire mmd_pkg::mmd_core_req_t core_req,
    input wire mmd_pkg::mmd_core_rsp_t core_rsp_ff,
    input wire mmd_pkg::mmd_mem_req_t flash_req_ff,
    input wire logic flash_ack,
    input wire logic [31:0] flash_rdata,
    input wire mmd_pkg::mmd_mem_req_t mmr_req_ff,
    input wire logic mmr_ack,
    input wire logic [31:0] mmr_rdata,
    input wire logic boot_done_ff,
    input wire logic download_mode_ff,
    input wire logic [7:0] remap_select_register_ff
);
    logic pend_ff;
    logic nxt_pend;
    logic taken, in_low, in_sram, in_flash, in_mmr, unmapped, hidden, ram_low, ack;
    logic [31:0] a;
    assign a = core_req.addr;
    assign ack = core_rsp_ff.ack;
    // Track the one outstanding request so held req is not taken twice
    assign taken = core_req.req && boot_done_ff && !pend_ff;
    assign in_low = a < mmd_pkg::LOW_WIN_SIZE;
    assign in_sram = (a - mmd_pkg::SRAM_BASE) < 32'(SRAM_WORDS * 4);
    assign in_flash = (a - mmd_pkg::FLASH_BASE) < mmd_pkg::FLASH_SIZE;
    assign in_mmr = (a - mmd_pkg::MMR_BASE) < mmd_pkg::MMR_SIZE;
    assign unmapped = !(in_low || in_sram || in_flash || in_mmr);
    assign hidden = in_flash && !core_req.kernel
        && (a - mmd_pkg::FLASH_BASE) >= mmd_pkg::FLASH_USER_SIZE;
    assign ram_low = in_low && remap_select_register_ff[0] && a < 32'(SRAM_WORDS * 4);
    always_comb begin
        nxt_pend = reset ? 1'b0 : (taken ? 1'b1 : (ack ? 1'b0 : pend_ff));
    end
    always_ff @(posedge ref_clk) begin
        pend_ff <= nxt_pend;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_reset_clear: assert property (
        $fell(reset) |-> remap_select_register_ff == 8'h00 && !ack && !boot_done_ff)
        else $error("state not cleared by reset");
    a_reserved_zero: assert property (
        remap_select_register_ff[7:1] == 7'h00) else $error("reserved remap bits set");
    a_remap_write: assert property (
        taken && core_req.wr && a == mmd_pkg::REMAP_ADDR |=> ack && !core_rsp_ff.abort
        && remap_select_register_ff == {7'h00, $past(core_req.wdata[0])})
        else $error("remap write wrong");
    a_remap_read: assert property (
        taken && !core_req.wr && a == mmd_pkg::REMAP_ADDR && core_req.size == mmd_pkg::SZ_WORD
        |=> ack && core_rsp_ff.rdata == {24'h0, remap_select_register_ff})
        else $error("remap read wrong");
    a_unmapped_abort: assert property (
        taken && unmapped |=> ack && core_rsp_ff.abort) else $error("unmapped not aborted");
    a_hidden_abort: assert property (
        taken && hidden |=> ack && core_rsp_ff.abort) else $error("hidden area reached");
    a_sram_latency: assert property (
        taken && (in_sram || ram_low) |=> !ack ##1 (ack && !core_rsp_ff.abort))
        else $error("ram answer timing wrong");
    a_flash_mirror: assert property (
        taken && in_low && !remap_select_register_ff[0] |=> flash_req_ff.valid
        && ((flash_req_ff.addr - mmd_pkg::FLASH_BASE) >> 2) == ($past(a) >> 2))
        else $error("low window not sent to flash");
    a_mmr_forward: assert property (
        taken && in_mmr && (a >> 2) != (mmd_pkg::REMAP_ADDR >> 2)
        |=> mmr_req_ff.valid && (mmr_req_ff.addr >> 2) == ($past(a) >> 2))
        else $error("register access not forwarded");
    a_flash_data: assert property (
        pend_ff && flash_ack && !core_req.wr && core_req.size == mmd_pkg::SZ_WORD
        && a[1:0] == 2'h0 |=> ack && core_rsp_ff.rdata == $past(flash_rdata))
        else $error("flash word not returned");
    a_boot_gate: assert property (
        !boot_done_ff |-> !ack) else $error("answer before boot done");
endmodule

bind mmd_decoder mmd_decoder_properties #(.SRAM_WORDS(SRAM_WORDS), .PAGE_WORDS(PAGE_WORDS))
    mmd_decoder_properties_inst (.ref_clk, .reset, .core_req, .core_rsp_ff, .flash_req_ff,
    .flash_ack, .flash_rdata, .mmr_req_ff, .mmr_ack, .mmr_rdata, .boot_done_ff,
    .download_mode_ff, .remap_select_register_ff);
`default_nettype wire

/* tb/mmd_mem_model.sv */
// Behavioural program memory or register block behind the decoder.
// Assumes one-cycle valid pulses; answers each with one ack pulse.
`default_nettype none

module mmd_mem_model #(
    parameter int PAGE_WORDS = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic [1:0] mode,
    input wire mmd_pkg::mmd_mem_req_t req,
    output logic ack_ff,
    output logic [31:0] rdata_ff
);
    logic busy_ff;
    logic [1:0] wait_ff;
    logic [31:0] addr_ff;
    logic [31:0] sum;
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {~a[15:0], a[15:0]};
    endfunction
    // Mode 0 signature, 1 page checksum, 2 neither, 3 plain pattern
    always_comb begin
        sum = 32'h0;
        for (int i = 0; i < PAGE_WORDS; i++) begin
            if (i != int'(mmd_pkg::SIG_ADDR >> 2)) begin
                sum += pat(mmd_pkg::FLASH_BASE + 32'(i * 4));
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        ack_ff <= 1'b0;
        // Idle data toggles so a stale word cannot pass for an answer
        rdata_ff <= ~rdata_ff;
        if (reset) begin
            busy_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else if (req.valid) begin
            busy_ff <= 1'b1;
            wait_ff <= slow ? 2'h3 : 2'h0;
            addr_ff <= req.addr;
        end else if (busy_ff && wait_ff != 2'h0) begin
            wait_ff <= wait_ff - 2'h1;
        end else if (busy_ff) begin
            busy_ff <= 1'b0;
            ack_ff <= 1'b1;
            if (mode == 2'h3 || addr_ff != mmd_pkg::FLASH_BASE + mmd_pkg::SIG_ADDR) begin
                rdata_ff <= pat(addr_ff);
            end else begin
                rdata_ff <= mode == 2'h0 ? mmd_pkg::SIG_VALUE : (mode == 2'h1 ? sum : 32'h0);
            end
        end
    end
endmodule
`default_nettype wire

/* tb/test_mmd_decoder.sv */
// Self-checking bench for the memory map and remap decoder.
// Assumes the behavioural responders stand in for flash and registers.
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", n, (e), (g)); end end

module test_mmd_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PW = 8;
    localparam logic RD = 1'h0, WR = 1'h1, U = 1'h0, K = 1'h1, NA = 1'h0, AB = 1'h1;
    localparam logic [1:0] B = mmd_pkg::SZ_BYTE, H = mmd_pkg::SZ_HALF, W = mmd_pkg::SZ_WORD;
    localparam logic [31:0] M8 = 32'hFF, M16 = 32'hFFFF, M32 = 32'hFFFF_FFFF;
    localparam logic [31:0] RA = mmd_pkg::REMAP_ADDR;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic slow = 1'h0;
    logic [1:0] mode = 2'h0;
    mmd_pkg::mmd_core_req_t core_req = '0;
    mmd_pkg::mmd_core_rsp_t core_rsp_ff;
    mmd_pkg::mmd_mem_req_t flash_req_ff, mmr_req_ff;
    logic flash_ack, mmr_ack, boot_done_ff, download_mode_ff, ab;
    logic [31:0] flash_rdata, mmr_rdata, q;
    logic [7:0] remap_select_register_ff;
    logic [31:0] bad [5] = '{32'h3_0000, 32'h1_7800, 32'h9_8000, 32'h2000_0000, 32'hFFFE_FFFC};
    int failures = 0;
    int cmp_count = 0;
    always #10 ref_clk = ~ref_clk;

    mmd_decoder #(.PAGE_WORDS(PW)) mmd_decoder_inst (.ref_clk, .reset, .core_req,
        .core_rsp_ff, .flash_req_ff, .flash_ack, .flash_rdata, .mmr_req_ff, .mmr_ack,
        .mmr_rdata, .boot_done_ff, .download_mode_ff, .remap_select_register_ff);
    mmd_mem_model #(.PAGE_WORDS(PW)) flash_model (.ref_clk, .reset, .slow, .mode,
        .req(flash_req_ff), .ack_ff(flash_ack), .rdata_ff(flash_rdata));
    mmd_mem_model #(.PAGE_WORDS(PW)) mmr_model (.ref_clk, .reset, .slow, .mode(2'h3),
        .req(mmr_req_ff), .ack_ff(mmr_ack), .rdata_ff(mmr_rdata));

    task automatic conclude();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Request held until ack is seen, then dropped at once: a req still high
    // at the next edge would be taken as a second request
    task automatic tr(input logic w, k, input logic [1:0] sz, input logic [31:0] a, d, e, m,
                      input logic eab);
        int n;
        @(posedge ref_clk);
        #1;
        core_req = '{1'h1, w, k, sz, a, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (core_rsp_ff.ack !== 1'h1 && n < 40);
        if (core_rsp_ff.ack !== 1'h1) begin
            failures++;
            conclude();
        end
        q = core_rsp_ff.rdata;
        ab = core_rsp_ff.abort;
        core_req.req = 1'h0;
        `CHK("abort", eab, ab)
        if (!eab && !w) `CHK("rdata", e & m, q & m)
    endtask

    task automatic boot(input logic [1:0] md);
        int n;
        mode = md;
        reset = 1'h1;
        repeat (2) @(posedge ref_clk);
        #1;
        reset = 1'h0;
        n = 0;
        while (boot_done_ff !== 1'h1 && download_mode_ff !== 1'h1 && n < 300) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (boot_done_ff !== 1'h1 && download_mode_ff !== 1'h1) begin
            failures++;
            conclude();
        end
    endtask

    initial begin
        boot(2'h0);
        `CHK("boot_done", 1'h1, boot_done_ff)
        `CHK("download", 1'h0, download_mode_ff)
        `CHK("remap", 8'h00, remap_select_register_ff)
        tr(RD, U, W, RA, 32'h0, 32'h0, M32, NA);
        tr(RD, U, W, mmd_pkg::SIG_ADDR, 32'h0, mmd_pkg::SIG_VALUE, M32, NA);
        tr(RD, U, W, 32'h100, 32'h0, 32'hFEFF_0100, M32, NA);
        tr(WR, U, W, 32'h4_0000, 32'h1122_3344, 32'h0, M32, NA);
        tr(WR, U, W, 32'h4_0004, 32'h0, 32'h0, M32, NA);
        tr(WR, U, B, 32'h4_0005, 32'hAB, 32'h0, M32, NA);
        tr(WR, U, H, 32'h4_0006, 32'hCDEF, 32'h0, M32, NA);
        tr(RD, U, W, 32'h4_0004, 32'h0, 32'hCDEF_AB00, M32, NA);
        tr(RD, U, B, 32'h4_0001, 32'h0, 32'h33, M8, NA);
        tr(RD, U, H, 32'h4_0002, 32'h0, 32'h1122, M16, NA);
        tr(WR, U, W, 32'h4_17FC, 32'hA5A5_5A5A, 32'h0, M32, NA);
        tr(RD, U, W, 32'h4_17FC, 32'h0, 32'hA5A5_5A5A, M32, NA);
        tr(RD, U, W, 32'h4_1800, 32'h0, 32'h0, M32, AB);
        tr(WR, U, W, RA, 32'h1, 32'h0, M32, NA);
        tr(RD, U, W, RA, 32'h0, 32'h1, M32, NA);
        tr(RD, U, W, 32'h4, 32'h0, 32'hCDEF_AB00, M32, NA);
        tr(RD, U, W, 32'h1800, 32'h0, 32'h0, M32, AB);
        tr(WR, U, W, RA, 32'h0, 32'h0, M32, NA);
        tr(RD, U, W, 32'h100, 32'h0, 32'hFEFF_0100, M32, NA);
        foreach (bad[i]) begin
            tr(RD, U, W, bad[i], 32'h0, 32'h0, M32, AB);
            tr(WR, U, W, bad[i], 32'h0, 32'h0, M32, AB);
        end
        slow = 1'h1;
        tr(RD, U, W, 32'h9_7800, 32'h0, 32'h0, M32, AB);
        tr(RD, K, W, 32'h9_7800, 32'h0, 32'h87FF_7800, M32, NA);
        tr(RD, U, W, 32'h9_77FC, 32'h0, 32'h8803_77FC, M32, NA);
        tr(RD, U, W, 32'hFFFF_0230, 32'h0, 32'hFDCF_0230, M32, NA);
        tr(RD, U, W, 32'hFFFF_0FFC, 32'h0, 32'hF003_0FFC, M32, NA);
        tr(WR, U, W, RA, 32'h1, 32'h0, M32, NA);
        boot(2'h1);
        `CHK("boot_done", 1'h1, boot_done_ff)
        `CHK("download", 1'h0, download_mode_ff)
        `CHK("remap", 8'h00, remap_select_register_ff)
        tr(RD, U, W, 32'h100, 32'h0, 32'hFEFF_0100, M32, NA);
        boot(2'h2);
        `CHK("download", 1'h1, download_mode_ff)
        conclude();
    end
endmodule
`default_nettype wire
